// ===== core/pvdma_pkg.sv
package pvdma_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFS_CTL = 12'h200;
  localparam logic [11:0] OFS_PCI = 12'h204;
  localparam logic [11:0] OFS_CNT = 12'h208;
  localparam logic [11:0] OFS_BP = 12'h210;
  localparam logic [11:0] OFS_GCS = 12'h220;
  localparam logic [11:0] OFS_PTR = 12'h224;
  // transfer_control_reg fields
  localparam int CTL_DIR = 31;
  localparam int CTL_FIXED = 23;
  localparam int CTL_WID = 16;
  localparam int CTL_SPACE = 12;
  localparam int CTL_BLOCK = 8;
  localparam int CTL_PCIW = 7;
  // general_control_status_reg fields
  localparam int GCS_GO = 31;
  localparam int GCS_STOP_REQ = 30;
  localparam int GCS_CHAIN = 27;
  localparam int GCS_TEN = 20;
  localparam int GCS_OFF = 16;
  localparam int GCS_ACT = 15;
  localparam int GCS_STOPPED = 11;
  localparam int GCS_DONE = 10;
  localparam int GCS_XERR = 9;
  localparam int GCS_PERR = 8;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  // Width and space codes
  localparam logic [1:0] W_D8 = 2'h0;
  localparam logic [1:0] W_D16 = 2'h1;
  localparam logic [1:0] W_D32 = 2'h2;
  localparam logic [1:0] W_D64 = 2'h3;
  localparam logic [1:0] SP_A24 = 2'h1;
  localparam logic [1:0] SP_A32 = 2'h2;
  // ****************************************
  // Counts and timing
  // ****************************************
  localparam int CNT_W = 25;
  localparam logic [14:0] TEN_FIXED_BASE = 15'h0080;
  localparam logic [14:0] TEN_INC_BASE = 15'h0100;
  localparam int CLK_MHZ = 125;
  localparam int BACKOFF_UNIT_US = 16;
  localparam int BACKOFF_UNIT_CYC = BACKOFF_UNIT_US * CLK_MHZ;
  localparam logic [2:0] PKT_LAST_IDX = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_FETCH, ST_XFER, ST_BACKOFF
  } pvdma_state_e;
  typedef struct packed {
    logic [31:0] pci_addr;
    logic [31:0] bp_addr;
    logic [3:0] size;
    logic [7:0] pci_be;
    logic block;
    logic to_bp;
    logic pci_wide;
  } pvdma_xfer_s;
endpackage : pvdma_pkg

// ===== core/pvdma_core.sv
`timescale 1ns/1ns
// What this block does
// [RQ1] Fixed mode holds backplane address, direct and chained.
// [RQ2] Fixed mode issues only 8/16/32-bit single cycles, no blocks.
// [RQ3] Writing one to fixed_address_enable selects fixed mode.
// [RQ4] Software sets tenure, then both addresses, then launch.
// [RQ5] No backplane address reads in fixed mode; rewrite it after stop.
// [RQ6] At tenure limit the backplane master pauses until backoff expires.
// [RQ7] Fixed-mode tenure codes 001..111 give 128..8192 bytes.
// [RQ8] Fixed launch flags error on block, bad width or alignment; D16 is flagged at even, not odd, addresses.
// [RQ9] Byte count takes 1 byte to 16 MBytes, any alignment.
// [RQ10] Narrower aligned cycles fill gaps; partial lanes on last beat.
// [RQ11] Narrow cycles until width aligned, full width, narrow tail.
// [RQ12] Count frozen while active, zero when done, remainder on stop/error.
// [RQ13] Zero-count launch idles, or fetches a packet when chaining.
// [RQ14] Packets sit on 32-byte boundaries; pointer keeps bits 31:5 only.
// [RQ15] After a transfer completes, fetch the next packet and run it.
// [RQ16] Width field selects D08, D16, D32, D64 with block variants.
// [RQ17] Block enable counts only for A24/A32 below 64 bits; D64 may burst.
// [RQ18] PCI wide enable acts only on a 64-bit bus.
// [RQ19] Software programs the widest width the destination accepts.
// [RQ20] Writing one clears each status bit, also alongside launch.
// [RQ21] Direction bit set moves PCI to backplane, clear the reverse.
// [RQ22] Tenure code 000 disables the limit.
module pvdma_core
  import pvdma_pkg::*;
#(
  parameter int BACKOFF_CYC = BACKOFF_UNIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bus64_strap,
  output logic xfer_req,
  output pvdma_xfer_s xfer,
  input wire logic xfer_ack,
  input wire logic xfer_err,
  output logic pkt_req,
  output logic [31:0] pkt_addr,
  input wire logic pkt_ack,
  input wire logic [31:0] pkt_rdata
);
  // ****************************************
  // Declarations
  // ****************************************
  pvdma_state_e state_q;
  logic wait_q, s1_q, s2_q;
  logic [31:0] rdata_q, ctl_q, pci_q, bp_q, w_pci_q, w_bp_q, pkt_addr_q;
  logic [CNT_W-1:0] cnt_q, w_rem_q;
  logic [26:0] ptr_q;
  logic chain_q, stop_req_q, done_q, stopped_q, xerr_q, perr_q;
  logic [2:0] ten_code_q, pkt_idx_q;
  logic [3:0] off_code_q;
  logic [14:0] ten_q;
  logic [15:0] off_q;
  logic from_fetch_q, last_q, w_fixed_q, xfer_req_q, pkt_req_q;
  pvdma_xfer_s xfer_q;
  // ****************************************
  // Bus decode
  // ****************************************
  wire req = avs_read | avs_write;
  wire acc = req & ~wait_q;
  wire wr = avs_write & acc;
  wire active = state_q != ST_IDLE;
  wire [31:0] bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wd = avs_writedata & bm;
  wire hit_ctl = avs_address == OFS_CTL;
  wire hit_pci = avs_address == OFS_PCI;
  wire hit_cnt = avs_address == OFS_CNT;
  wire hit_bp = avs_address == OFS_BP;
  wire hit_gcs = avs_address == OFS_GCS;
  wire hit_ptr = avs_address == OFS_PTR;
  wire wr_cfg = wr & ~active;
  wire wr_gcs = wr & hit_gcs;
  wire [31:0] gcs_rd = {1'b0, stop_req_q, 2'h0, chain_q, 4'h0,
                        ten_code_q, off_code_q, active, 3'h0, stopped_q,
                        done_q, xerr_q, perr_q, 8'h00};
  wire [31:0] rd_mux = hit_ctl ? ctl_q : hit_pci ? pci_q : hit_bp ? bp_q :
                       hit_cnt ? {7'h00, cnt_q} : hit_gcs ? gcs_rd :
                       hit_ptr ? {ptr_q, 5'h00} : 32'h0000_0000;
  // [RQ20] W1C status clear
  wire clr_stop = wr_gcs & wd[GCS_STOPPED];
  wire clr_done = wr_gcs & wd[GCS_DONE];
  wire clr_xerr = wr_gcs & wd[GCS_XERR];
  wire clr_perr = wr_gcs & wd[GCS_PERR];
  wire st_left = (stopped_q & ~clr_stop) | (done_q & ~clr_done) |
                 (xerr_q & ~clr_xerr) | (perr_q & ~clr_perr);
  wire go_ok = wr_gcs & wd[GCS_GO] & ~active & ~st_left;
  // ****************************************
  // Cycle sizing
  // ****************************************
  // [RQ16] Width field decode
  wire [1:0] wcode = ctl_q[CTL_WID+:2];
  wire [1:0] space = ctl_q[CTL_SPACE+:2];
  wire [3:0] wmax = 4'h1 << wcode;
  wire [2:0] lo = w_bp_q[2:0];
  // [RQ11] Largest aligned size that fits
  wire c8 = wcode == W_D64 && lo == 3'h0 && w_rem_q >= CNT_W'(8);
  wire c4 = wcode >= W_D32 && lo[1:0] == 2'h0 && w_rem_q >= CNT_W'(4);
  wire c2 = wcode >= W_D16 && lo[0] == 1'b0 && w_rem_q >= CNT_W'(2);
  wire [3:0] chunk = c8 ? 4'h8 : c4 ? 4'h4 : c2 ? 4'h2 : 4'h1;
  // [RQ10] Byte lanes of the PCI beat
  wire [7:0] be_mask = (8'h01 << chunk) - 8'h01;
  // [RQ17] Block cycle qualification
  wire blk_ok = ctl_q[CTL_BLOCK] && (space == SP_A24 || space == SP_A32) &&
                wcode != W_D64;
  // [RQ2] Never a block cycle in fixed mode
  wire use_blk = ~w_fixed_q && chunk == wmax && (blk_ok || wcode == W_D64);
  wire [CNT_W-1:0] rem_nx = w_rem_q - CNT_W'(chunk);
  wire [14:0] ten_nx = ten_q + 15'(chunk);
  // [RQ7] Tenure byte limit by mode
  wire [14:0] ten_lim = (w_fixed_q ? TEN_FIXED_BASE : TEN_INC_BASE) <<
                        (ten_code_q - 3'h1);
  // [RQ22] Code zero never trips
  wire ten_hit = ten_code_q != 3'h0 && ten_nx >= ten_lim;
  // [RQ8] Launch checks
  wire [1:0] lw = ctl_q[CTL_WID+:2];
  wire perr_fix = ctl_q[CTL_BLOCK] || (lw == W_D16 && ~bp_q[0]) ||
                  (lw == W_D32 && bp_q[1:0] != 2'h0) || lw == W_D64;
  wire perr_cond = (ctl_q[CTL_FIXED] & perr_fix) | (pci_q[2:0] != bp_q[2:0]);
  wire beat_done = state_q == ST_XFER && xfer_req_q && xfer_ack;
  wire [15:0] off_load = 16'(off_code_q * BACKOFF_CYC);
  // ****************************************
  // Bus slave
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= RST_VAL;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= bus64_strap;
      s2_q <= s1_q;
    end
  end
  // ****************************************
  // Control fields and status
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_q <= 1'b0;
      ten_code_q <= 3'h0;
      off_code_q <= 4'h0;
      stop_req_q <= 1'b0;
      done_q <= 1'b0;
      stopped_q <= 1'b0;
      xerr_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      if (wr_gcs && !active) begin
        chain_q <= wd[GCS_CHAIN];
        ten_code_q <= wd[GCS_TEN+:3];
        off_code_q <= wd[GCS_OFF+:4];
      end
      if (wr_gcs && wd[GCS_STOP_REQ] && active) begin
        stop_req_q <= 1'b1;
      end else if (!active) begin
        stop_req_q <= 1'b0;
      end
      // [RQ20] Hardware set beats clear
      done_q <= (done_q & ~clr_done) | (state_q == ST_START &&
                cnt_q == '0 && !(chain_q && !last_q) && from_fetch_q) |
                (beat_done && !xfer_err && rem_nx == '0 &&
                !(chain_q && !last_q));
      stopped_q <= (stopped_q & ~clr_stop) | (beat_done && !xfer_err &&
                   rem_nx != '0 && stop_req_q);
      xerr_q <= (xerr_q & ~clr_xerr) | (beat_done & xfer_err);
      perr_q <= (perr_q & ~clr_perr) | (state_q == ST_START &&
                cnt_q != '0 && perr_cond);
    end
  end
  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      ctl_q <= RST_VAL;
      pci_q <= RST_VAL;
      bp_q <= RST_VAL;
      cnt_q <= '0;
      ptr_q <= '0;
      w_pci_q <= RST_VAL;
      w_bp_q <= RST_VAL;
      w_rem_q <= '0;
      w_fixed_q <= 1'b0;
      ten_q <= '0;
      off_q <= '0;
      pkt_idx_q <= 3'h0;
      pkt_addr_q <= RST_VAL;
      pkt_req_q <= 1'b0;
      from_fetch_q <= 1'b0;
      last_q <= 1'b0;
      xfer_req_q <= 1'b0;
      xfer_q <= '0;
    end else begin
      // [RQ3] Fixed mode bit lands in control
      if (wr_cfg && hit_ctl) ctl_q <= wd;
      if (wr_cfg && hit_pci) pci_q <= wd;
      // [RQ9] Up to 16 MBytes
      if (wr_cfg && hit_cnt) cnt_q <= wd[CNT_W-1:0];
      if (wr_cfg && hit_bp) bp_q <= wd;
      // [RQ14] Pointer keeps 31:5
      if (wr_cfg && hit_ptr) ptr_q <= wd[31:5];
      case (state_q)
        ST_IDLE: begin
          if (go_ok) begin
            state_q <= ST_START;
            from_fetch_q <= 1'b0;
            last_q <= 1'b0;
          end
        end
        ST_START: begin
          if (cnt_q != '0) begin
            state_q <= perr_cond ? ST_IDLE : ST_XFER;
            w_pci_q <= pci_q;
            w_bp_q <= bp_q;
            w_rem_q <= cnt_q;
            w_fixed_q <= ctl_q[CTL_FIXED];
            ten_q <= '0;
          // [RQ13] Zero count: chain or stop
          end else if (chain_q && !last_q) begin
            state_q <= ST_FETCH;
            pkt_req_q <= 1'b1;
            pkt_addr_q <= {ptr_q, 5'h00};
            pkt_idx_q <= 3'h0;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (pkt_ack) begin
            case (pkt_idx_q)
              3'h0: ctl_q <= pkt_rdata;
              3'h1: cnt_q <= pkt_rdata[CNT_W-1:0];
              3'h2: pci_q <= pkt_rdata;
              3'h3: bp_q <= pkt_rdata;
              default: begin
                ptr_q <= pkt_rdata[31:5];
                last_q <= pkt_rdata[0];
              end
            endcase
            pkt_idx_q <= pkt_idx_q + 3'h1;
            pkt_addr_q <= pkt_addr_q + 32'h0000_0004;
            if (pkt_idx_q == PKT_LAST_IDX) begin
              pkt_req_q <= 1'b0;
              from_fetch_q <= 1'b1;
              state_q <= ST_START;
            end
          end
        end
        ST_XFER: begin
          if (!xfer_req_q) begin
            xfer_req_q <= 1'b1;
            xfer_q.pci_addr <= w_pci_q;
            xfer_q.bp_addr <= w_bp_q;
            xfer_q.size <= chunk;
            xfer_q.pci_be <= be_mask << w_pci_q[2:0];
            xfer_q.block <= use_blk;
            // [RQ21] Direction from control
            xfer_q.to_bp <= ctl_q[CTL_DIR];
            // [RQ18] Wide only on 64-bit bus
            xfer_q.pci_wide <= ctl_q[CTL_PCIW] & s2_q;
          end else if (xfer_ack) begin
            xfer_req_q <= 1'b0;
            w_pci_q <= w_pci_q + 32'(chunk);
            // [RQ1] Fixed address never advances
            if (!w_fixed_q) w_bp_q <= w_bp_q + 32'(chunk);
            w_rem_q <= rem_nx;
            ten_q <= ten_nx;
            if (xfer_err) begin
              // [RQ12] Remainder kept on error
              cnt_q <= w_rem_q;
              state_q <= ST_IDLE;
            end else if (rem_nx == '0) begin
              cnt_q <= '0;
              pci_q <= w_pci_q + 32'(chunk);
              if (!w_fixed_q) bp_q <= w_bp_q + 32'(chunk);
              // [RQ15] Fetch next packet
              if (chain_q && !last_q) begin
                state_q <= ST_FETCH;
                pkt_req_q <= 1'b1;
                pkt_addr_q <= {ptr_q, 5'h00};
                pkt_idx_q <= 3'h0;
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (stop_req_q) begin
              cnt_q <= rem_nx;
              pci_q <= w_pci_q + 32'(chunk);
              state_q <= ST_IDLE;
            // [RQ6] Pause at tenure limit
            end else if (ten_hit) begin
              off_q <= off_load;
              state_q <= ST_BACKOFF;
            end
          end
        end
        ST_BACKOFF: begin
          if (off_q == 16'h0000) begin
            ten_q <= '0;
            state_q <= ST_XFER;
          end else begin
            off_q <= off_q - 16'h0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign xfer_req = xfer_req_q;
  assign xfer = xfer_q;
  assign pkt_req = pkt_req_q;
  assign pkt_addr = pkt_addr_q;
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_fixed_req;
    xfer_req_q && w_fixed_q;
  endsequence
  a_fixed_addr_hold: assert property ( // RQ1
    s_fixed_req |-> xfer_q.bp_addr == bp_q) else $error("fixed addr moved");
  a_fixed_no_block: assert property ( // RQ2
    s_fixed_req |-> !xfer_q.block && xfer_q.size <= 4'h4)
    else $error("block cycle in fixed mode");
  a_perr_on_launch: assert property ( // RQ8
    state_q == ST_START && cnt_q != '0 && perr_cond |=>
    perr_q && state_q == ST_IDLE) else $error("perr not raised");
  a_backoff_no_req: assert property ( // RQ6
    state_q == ST_BACKOFF |-> !xfer_req_q) else $error("req in backoff");
  a_aligned_cycle: assert property ( // RQ10
    xfer_req_q |-> (xfer_q.bp_addr[2:0] & 3'(xfer_q.size - 4'h1)) == 3'h0)
    else $error("unaligned cycle");
  a_count_frozen: assert property ( // RQ12
    state_q == ST_XFER ##1 state_q == ST_XFER |-> $stable(cnt_q))
    else $error("count changed while moving");
  a_done_count_zero: assert property ( // RQ12
    $rose(done_q) && !from_fetch_q |-> cnt_q == '0)
    else $error("done with count left");
  a_zero_idle: assert property ( // RQ13
    state_q == ST_START && cnt_q == '0 && !chain_q |=>
    state_q == ST_IDLE ##1 !xfer_req_q) else $error("zero count ran");
  a_pkt_aligned: assert property ( // RQ14
    pkt_req_q |-> pkt_addr_q[4:0] == {pkt_idx_q, 2'h0})
    else $error("packet not 32-byte aligned");
  a_w1c_clear: assert property ( // RQ20
    clr_done && !active |=> !done_q) else $error("done not cleared");
endmodule : pvdma_core

// ===== verif/pvdma_partner.sv
`timescale 1ns/1ns
// ****************************************
// Far-side model: PCI/backplane slaves
// ****************************************
module pvdma_partner
  import pvdma_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic xfer_req,
  output logic xfer_ack,
  output logic xfer_err,
  input wire logic pkt_req,
  input wire logic [31:0] pkt_addr,
  output logic pkt_ack,
  output logic [31:0] pkt_rdata,
  input wire logic [3:0] ack_dly,
  input wire logic err_en
);
  logic [31:0] mem [0:31];
  logic [3:0] wait_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_ack <= 1'b0;
      xfer_err <= 1'b0;
      wait_q <= 4'h0;
      pkt_ack <= 1'b0;
      pkt_rdata <= 32'h0;
    end else begin
      xfer_ack <= xfer_req && !xfer_ack && (wait_q >= ack_dly);
      xfer_err <= err_en && xfer_req && !xfer_ack && (wait_q >= ack_dly);
      wait_q <= (xfer_req && !xfer_ack) ? wait_q + 4'h1 : 4'h0;
      pkt_ack <= pkt_req && !pkt_ack;
      pkt_rdata <= (pkt_req && !pkt_ack) ? mem[pkt_addr[6:2]] : ~pkt_rdata;
    end
  end
endmodule : pvdma_partner

// ===== verif/tb.sv
`timescale 1ns/1ns
module tb
  import pvdma_pkg::*;
;
  localparam logic [31:0] G_GO = 32'h8000_0000;
  localparam logic [31:0] G_CLR = 32'h0000_0F00;
  localparam logic [31:0] S_MASK = 32'h0000_8F00;
  localparam logic [31:0] FIX = 32'h0080_0000;
  localparam logic [31:0] DIR = 32'h8000_0000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic xfer_req, xfer_ack, xfer_err, pkt_req, pkt_ack;
  pvdma_xfer_s xfer;
  logic [31:0] pkt_addr, pkt_rdata, q;
  logic [3:0] dly = 4'h0;
  logic strap = 1'b0;
  logic err_en = 1'b0;
  logic wide_exp = 1'b0;
  int err_count = 0;
  int num_checks = 0;
  int gap = 0;
  pvdma_xfer_s xq[$];
  int gq[$];
  logic [31:0] pq[$];
  always #4 ref_clk = ~ref_clk;
  pvdma_core #(.BACKOFF_CYC(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus64_strap(strap),
    .xfer_req(xfer_req), .xfer(xfer), .xfer_ack(xfer_ack),
    .xfer_err(xfer_err), .pkt_req(pkt_req), .pkt_addr(pkt_addr),
    .pkt_ack(pkt_ack), .pkt_rdata(pkt_rdata));
  pvdma_partner P (.ref_clk(ref_clk), .rst_b(rst_b), .xfer_req(xfer_req),
    .xfer_ack(xfer_ack), .xfer_err(xfer_err), .pkt_req(pkt_req),
    .pkt_addr(pkt_addr), .pkt_ack(pkt_ack), .pkt_rdata(pkt_rdata),
    .ack_dly(dly), .err_en(err_en));
  // ****************************************
  // Monitor of far-side traffic
  // ****************************************
  always @(posedge ref_clk) begin
    if (!xfer_req) gap++;
    if (xfer_req && xfer_ack) begin
      xq.push_back(xfer);
      gq.push_back(gap);
      gap = 0;
    end
    if (pkt_req && pkt_ack) pq.push_back(pkt_addr);
  end
  task end_of_test;
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic fail(input string msg);
    err_count++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail
  task automatic chk32(input logic [31:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask : chk32
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (!avs_waitrequest) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      fail("bus hang");
      end_of_test;
    end
  endtask : bus
  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000; i++) begin
      bus(1'b0, OFS_GCS, 32'h0);
      if (q[GCS_ACT] === 1'b0) break;
    end
    if (i == 2000) begin
      fail("stuck active");
      end_of_test;
    end
  endtask : wait_idle
  task automatic launch(input logic [31:0] ctl, pa, ba, cnt, gcs);
    bus(1'b1, OFS_GCS, gcs | G_CLR);
    bus(1'b1, OFS_CTL, ctl);
    bus(1'b1, OFS_PCI, pa);
    bus(1'b1, OFS_BP, ba);
    bus(1'b1, OFS_CNT, cnt);
    bus(1'b1, OFS_GCS, gcs | G_CLR | G_GO);
  endtask : launch
  task automatic chk_x(input logic [31:0] pa, ba, input logic [3:0] sz,
                       input logic tobp);
    pvdma_xfer_s x;
    if (xq.size() == 0) begin
      fail("missing cycle");
      return;
    end
    x = xq.pop_front();
    chk32(x.pci_addr, pa, "pci addr");
    chk32(x.bp_addr, ba, "bp addr");
    chk32({28'h0, x.size}, {28'h0, sz}, "size");
    chk32({24'h0, x.pci_be},
          {24'h0, 8'(((9'h1 << sz) - 9'h1) << pa[2:0])}, "byte lanes");
    chk32({31'h0, x.block}, 32'h0, "block");
    chk32({31'h0, x.to_bp}, {31'h0, tobp}, "direction");
    chk32({31'h0, x.pci_wide}, {31'h0, wide_exp}, "wide");
  endtask : chk_x
  initial begin
    #800000;
    fail("timeout");
    end_of_test;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] ctab [0:3];
    logic [31:0] atab [0:3];
    logic [31:0] ia [0:4];
    logic [3:0] isz [0:4];
    ctab = '{FIX | 32'h0000_2100, FIX | 32'h0001_0000,
             FIX | 32'h0002_0000, FIX | 32'h0003_0000};
    atab = '{32'h1000, 32'h1000, 32'h1002, 32'h1000};
    ia = '{32'h101, 32'h102, 32'h104, 32'h108, 32'h10C};
    isz = '{4'h1, 4'h2, 4'h4, 4'h4, 4'h4};
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_GCS, 32'h0);
    chk32(q, 32'h0, "gcs reset");
    bus(1'b0, 12'h0FC, 32'h0);
    chk32(q, 32'h0, "unmapped read");
    bus(1'b1, OFS_GCS, G_GO);
    wait_idle;
    chk32(q & S_MASK, 32'h0, "zero count status");
    chk32(32'(xq.size()), 32'h0, "zero count traffic");
    launch(DIR | FIX | 32'h0002_0000, 32'h2000, 32'h1000, 32'd12, 32'h0);
    wait_idle;
    for (int k = 0; k < 3; k++)
      chk_x(32'h2000 + 32'(4 * k), 32'h1000, 4'h4, 1'b1);
    chk32(q & S_MASK, 32'h0000_0400, "done status");
    bus(1'b0, OFS_CNT, 32'h0);
    chk32(q, 32'h0, "count after done");
    bus(1'b1, OFS_GCS, 32'h0000_0400);
    bus(1'b0, OFS_GCS, 32'h0);
    chk32(q & S_MASK, 32'h0, "done cleared");
    for (int k = 0; k < 4; k++) begin
      launch(ctab[k], atab[k], atab[k], 32'd4, 32'h0);
      wait_idle;
      chk32(q & S_MASK, 32'h0000_0100, "prog error");
      chk32(32'(xq.size()), 32'h0, "prog error traffic");
    end
    dly <= 4'h3;
    strap <= 1'b1;
    wide_exp = 1'b1;
    launch(32'h0002_2080, 32'h101, 32'h101, 32'd15, 32'h0);
    wait_idle;
    for (int k = 0; k < 5; k++) chk_x(ia[k], ia[k], isz[k], 1'b0);
    chk32(32'(xq.size()), 32'h0, "split count");
    dly <= 4'h0;
    gq.delete();
    launch(DIR | FIX, 32'h0, 32'h7000, 32'd130, 32'h0011_0000);
    bus(1'b0, OFS_GCS, 32'h0);
    chk32(q & 32'h0000_8000, 32'h0000_8000, "active");
    bus(1'b0, OFS_CNT, 32'h0);
    chk32(q, 32'd130, "count frozen");
    wait_idle;
    chk32(32'(xq.size()), 32'd130, "tenure traffic");
    if (xq.size() == 130) begin
      chk32(32'(gq[128] > gq[127] + 3), 32'h1, "backoff gap");
      chk32(32'(gq[127] < 4), 32'h1, "early pause");
      chk32(xq[129].bp_addr, 32'h7000, "fixed addr");
    end
    xq.delete();
    strap <= 1'b0;
    wide_exp = 1'b0;
    P.mem[16] = DIR | FIX | 32'h0000_0080;
    P.mem[17] = 32'd3;
    P.mem[18] = 32'h3001;
    P.mem[19] = 32'h5001;
    P.mem[20] = 32'h1;
    bus(1'b1, OFS_PTR, 32'h40);
    launch(32'h0, 32'h0, 32'h0, 32'h0, 32'h0800_0000);
    wait_idle;
    chk32(32'(pq.size()), 32'd5, "packet words");
    for (int k = 0; k < 5 && k < pq.size(); k++)
      chk32(pq[k], 32'h40 + 32'(4 * k), "packet addr");
    for (int k = 0; k < 3; k++)
      chk_x(32'h3001 + 32'(k), 32'h5001, 4'h1, 1'b1);
    chk32(q & S_MASK, 32'h0000_0400, "chain done");
    chk32(q & 32'h0800_0000, 32'h0800_0000, "chain bit");
    err_en <= 1'b1;
    launch(32'h0, 32'h100, 32'h100, 32'd5, 32'h0);
    wait_idle;
    err_en <= 1'b0;
    chk32(q & S_MASK, 32'h0000_0200, "bus error status");
    chk_x(32'h100, 32'h100, 4'h1, 1'b0);
    bus(1'b0, OFS_CNT, 32'h0);
    chk32(q, 32'd5, "count after error");
    end_of_test;
  end
endmodule : tb
